// File: src/hotplug_adc_slot_control_regs.sv
`timescale 1ns/1ps
module hotplug_adc_slot_control_regs
   import slot_ctrl_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = CONV_WAIT_CYCLES - CONV_MARGIN_CYCLES,
   parameter logic [7:0] TIMEOUT_RESULT = 8'hFF
)
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // register port from the serial framing logic
   input wire logic [7:0] reg_cmd_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // converter
   output logic conv_start_out,
   output logic conv_slot_out,
   output logic conv_quantity_out,
   output logic [2:0] conv_supply_out,
   input wire logic conv_done_in,
   input wire logic [7:0] conv_data_in,
   // slot a pins
   input wire logic slot_a_override_n_in,
   input wire logic slot_a_aux_good_in,
   input wire logic slot_a_main_good_in,
   output logic slot_a_main_on_out,
   output logic slot_a_aux_on_out,
   output logic slot_a_good_n_out,
   output logic slot_a_good_n_oe_out,
   // slot b pins
   input wire logic slot_b_override_n_in,
   input wire logic slot_b_aux_good_in,
   input wire logic slot_b_main_good_in,
   output logic slot_b_main_on_out,
   output logic slot_b_aux_on_out,
   output logic slot_b_good_n_out,
   output logic slot_b_good_n_oe_out
);

   localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
   localparam int NSYNC = 3 * NUM_SLOTS;
   // override pins idle high, good comparators idle low
   localparam logic [NSYNC-1:0] SYNC_RESET = 6'h09;

   // ***********************************************
   // reset release
   // ***********************************************
   logic [1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rst_sync_q <= 2'b00;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   assign rst_n = rst_sync_q[1];

   // ***********************************************
   // pin synchronisers
   // ***********************************************
   logic [NSYNC-1:0] pin_raw;
   logic [NSYNC-1:0] sync1_q;
   logic [NSYNC-1:0] sync2_q;

   // per slot: {main_good, aux_good, override_n}
   assign pin_raw = {slot_b_main_good_in, slot_b_aux_good_in, slot_b_override_n_in,
                     slot_a_main_good_in, slot_a_aux_good_in, slot_a_override_n_in};

   genvar s;
   generate
      for (s = 0; s < NSYNC; s++)
      begin : g_sync
         always_ff @(posedge clock_in or negedge rst_n)
         begin
            if (!rst_n)
            begin
               sync1_q[s] <= SYNC_RESET[s];
               sync2_q[s] <= SYNC_RESET[s];
            end
            else
            begin
               sync1_q[s] <= pin_raw[s];
               sync2_q[s] <= sync1_q[s];
            end
         end
      end
   endgenerate

   // ***********************************************
   // command decode
   // ***********************************************
   logic cmd_valid;
   logic wr_conv;
   logic [NUM_SLOTS-1:0] wr_slot;

   // commands above 0x07 are never decoded to any register
   assign cmd_valid = (reg_cmd_in <= CMD_LAST_VALID);
   assign wr_conv = reg_wr_in && cmd_valid && (reg_cmd_in == CMD_CONV_CTRL);
   assign wr_slot[0] = reg_wr_in && cmd_valid && (reg_cmd_in == CMD_SLOT_A);
   assign wr_slot[1] = reg_wr_in && cmd_valid && (reg_cmd_in == CMD_SLOT_B);

   // ***********************************************
   // conversion control register
   // ***********************************************
   conv_state_t state_q;
   logic busy_q;
   logic slot_sel_q;
   logic qty_q;
   logic [2:0] supply_q;
   logic start_q;
   logic [CW-1:0] count_q;
   logic [7:0] result_q;
   logic conv_accept;
   logic [2:0] wr_supply;
   logic timeout_hit;

   assign wr_supply = reg_wdata_in[CONV_SUP_LSB +: CONV_SUP_W];
   // writes during a conversion are refused whole, so the running
   // selection stays stable until its result lands
   assign conv_accept = wr_conv && !busy_q;
   assign timeout_hit = (count_q == CW'(TIMEOUT_CYCLES - 1));

   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         slot_sel_q <= CONV_CTRL_RESET[CONV_SLOT_BIT];
         qty_q <= CONV_CTRL_RESET[CONV_QTY_BIT];
         supply_q <= CONV_CTRL_RESET[CONV_SUP_LSB +: CONV_SUP_W];
      end
      else if (conv_accept)
      begin
         // one byte carries all three selections
         slot_sel_q <= reg_wdata_in[CONV_SLOT_BIT];
         qty_q <= reg_wdata_in[CONV_QTY_BIT];
         supply_q <= wr_supply;
      end
   end

   // ***********************************************
   // conversion sequencer
   // ***********************************************
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= CONV_IDLE;
         busy_q <= CONV_CTRL_RESET[CONV_BUSY_BIT];
      end
      else
      begin
         case (state_q)
            CONV_IDLE:
            begin
               // code 000 stores the selection but starts nothing; the
               // undefined codes are passed on to the converter unchanged
               if (conv_accept && (wr_supply != SUP_NONE))
               begin
                  state_q <= CONV_LAUNCH;
                  busy_q <= 1'b1;
               end
            end
            CONV_LAUNCH:
            begin
               state_q <= CONV_WAIT;
            end
            CONV_WAIT:
            begin
               if (conv_done_in || timeout_hit)
               begin
                  state_q <= CONV_IDLE;
                  busy_q <= 1'b0;
               end
            end
            default:
            begin
               state_q <= CONV_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
         start_q <= 1'b0;
      else
         start_q <= (state_q == CONV_IDLE) && conv_accept && (wr_supply != SUP_NONE);
   end

   // bounds the wait so busy always clears inside the host's fixed wait
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
         count_q <= '0;
      else if (state_q != CONV_WAIT)
         count_q <= '0;
      else if (!timeout_hit)
         count_q <= count_q + CW'(1);
   end

   // ***********************************************
   // result register
   // ***********************************************
   // a silent converter leaves a marker value instead of a stale sample
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
         result_q <= RESULT_RESET;
      else if (state_q == CONV_WAIT)
      begin
         if (conv_done_in)
            result_q <= conv_data_in;
         else if (timeout_hit)
            result_q <= TIMEOUT_RESULT;
      end
   end

   // ***********************************************
   // slot controllers
   // ***********************************************
   slot_if slot_bus[NUM_SLOTS] ();

   genvar g;
   generate
      for (g = 0; g < NUM_SLOTS; g++)
      begin : g_slot
         assign slot_bus[g].wr = wr_slot[g];
         assign slot_bus[g].wdata = reg_wdata_in;
         assign slot_bus[g].override_n = sync2_q[3 * g];
         assign slot_bus[g].aux_good = sync2_q[3 * g + 1];
         assign slot_bus[g].main_good = sync2_q[3 * g + 2];

         slot_power_ctrl u_slot (
            .clock_in (clock_in),
            .rst_n_in (rst_n),
            .bus (slot_bus[g])
         );
      end
   endgenerate

   // ***********************************************
   // register read
   // ***********************************************
   logic [7:0] rd_mux;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic [7:0] slot_a_rdata;
   logic [7:0] slot_b_rdata;

   assign slot_a_rdata = slot_bus[0].rdata;
   assign slot_b_rdata = slot_bus[1].rdata;

   always_comb
   begin
      rd_mux = READ_IDLE;
      if (cmd_valid)
      begin
         case (reg_cmd_in)
            CMD_RESULT: rd_mux = result_q;
            CMD_CONV_CTRL: rd_mux = {busy_q, 2'b00, slot_sel_q, qty_q, supply_q};
            CMD_SLOT_A: rd_mux = slot_a_rdata;
            CMD_SLOT_B: rd_mux = slot_b_rdata;
            default: rd_mux = READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= READ_IDLE;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= reg_rd_in;
         if (reg_rd_in)
            rdata_q <= rd_mux;
      end
   end

   // ***********************************************
   // power-good pin level
   // ***********************************************
   // open-drain: the pin is only ever pulled low, the enable does the work
   logic [NUM_SLOTS-1:0] good_level_q;

   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
         good_level_q <= '0;
      else
         good_level_q <= '0;
   end

   // ***********************************************
   // outputs
   // ***********************************************
   assign reg_rdata_out = rdata_q;
   assign reg_rvalid_out = rvalid_q;
   assign conv_start_out = start_q;
   assign conv_slot_out = slot_sel_q;
   assign conv_quantity_out = qty_q;
   assign conv_supply_out = supply_q;
   assign slot_a_main_on_out = slot_bus[0].main_on;
   assign slot_a_aux_on_out = slot_bus[0].aux_on;
   assign slot_a_good_n_out = good_level_q[0];
   assign slot_a_good_n_oe_out = slot_bus[0].good_drive;
   assign slot_b_main_on_out = slot_bus[1].main_on;
   assign slot_b_aux_on_out = slot_bus[1].aux_on;
   assign slot_b_good_n_out = good_level_q[1];
   assign slot_b_good_n_oe_out = slot_bus[1].good_drive;

endmodule : hotplug_adc_slot_control_regs

// File: shared/slot_ctrl_pkg.sv
package slot_ctrl_pkg;

   // ***********************************************
   // command bytes
   // ***********************************************
   localparam logic [7:0] CMD_RESULT = 8'h00;
   localparam logic [7:0] CMD_CONV_CTRL = 8'h01;
   localparam logic [7:0] CMD_SLOT_A = 8'h02;
   localparam logic [7:0] CMD_SLOT_B = 8'h03;
   localparam logic [7:0] CMD_LAST_VALID = 8'h07;

   // ***********************************************
   // field positions
   // ***********************************************
   localparam int CONV_BUSY_BIT = 7;
   localparam int CONV_SLOT_BIT = 4;
   localparam int CONV_QTY_BIT = 3;
   localparam int CONV_SUP_LSB = 0;
   localparam int CONV_SUP_W = 3;
   localparam int SLOT_AUX_GOOD_BIT = 7;
   localparam int SLOT_MAIN_GOOD_BIT = 6;
   localparam int SLOT_GATE_BIT = 2;
   localparam int SLOT_MAIN_BIT = 1;
   localparam int SLOT_AUX_BIT = 0;

   // ***********************************************
   // supply codes
   // ***********************************************
   localparam logic [2:0] SUP_NONE = 3'h0;
   localparam logic [2:0] SUP_3V3 = 3'h1;
   localparam logic [2:0] SUP_12V = 3'h3;
   localparam logic [2:0] SUP_AUX = 3'h5;

   // ***********************************************
   // reset values
   // ***********************************************
   localparam logic [7:0] CONV_CTRL_RESET = 8'h00;
   localparam logic [7:0] SLOT_CTRL_RESET = 8'h00;
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] READ_IDLE = 8'h00;

   // ***********************************************
   // timing
   // ***********************************************
   localparam int unsigned CLOCK_HZ = 25_000_000;
   localparam int unsigned CONV_WAIT_MS = 100;
   localparam int unsigned CONV_WAIT_CYCLES = CONV_WAIT_MS * (CLOCK_HZ / 1000);
   localparam int unsigned CONV_MARGIN_CYCLES = 4;
   localparam int NUM_SLOTS = 2;

   typedef enum logic [1:0] {
      CONV_IDLE,
      CONV_LAUNCH,
      CONV_WAIT
   } conv_state_t;

endpackage : slot_ctrl_pkg

// File: shared/slot_if.sv
`timescale 1ns/1ps
interface slot_if;
   logic wr;
   logic [7:0] wdata;
   logic override_n;
   logic aux_good;
   logic main_good;
   logic [7:0] rdata;
   logic main_on;
   logic aux_on;
   logic good_drive;

   modport ctl (
      output wr, wdata, override_n, aux_good, main_good,
      input rdata, main_on, aux_on, good_drive
   );
   modport slot (
      input wr, wdata, override_n, aux_good, main_good,
      output rdata, main_on, aux_on, good_drive
   );
endinterface : slot_if

// File: src/slot_power_ctrl.sv
`timescale 1ns/1ps
module slot_power_ctrl
   import slot_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // controller side
   slot_if.slot bus
);

   logic gate_q;
   logic main_q;
   logic aux_q;
   logic main_on_q;
   logic aux_on_q;
   logic good_drive_q;
   logic forced;

   // ***********************************************
   // writable control bits
   // ***********************************************
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         gate_q <= SLOT_CTRL_RESET[SLOT_GATE_BIT];
         main_q <= SLOT_CTRL_RESET[SLOT_MAIN_BIT];
         aux_q <= SLOT_CTRL_RESET[SLOT_AUX_BIT];
      end
      else if (bus.wr)
      begin
         // only bits 2..0 are stored, the rest is dropped
         gate_q <= bus.wdata[SLOT_GATE_BIT];
         main_q <= bus.wdata[SLOT_MAIN_BIT];
         aux_q <= bus.wdata[SLOT_AUX_BIT];
      end
   end

   // override only acts while the gate bit is clear
   assign forced = !bus.override_n && !gate_q;

   // ***********************************************
   // output switches
   // ***********************************************
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         main_on_q <= 1'b0;
         aux_on_q <= 1'b0;
      end
      else
      begin
         // diagnostic override brings both switches up regardless of the main and aux bits
         main_on_q <= main_q || forced;
         aux_on_q <= aux_q || forced;
      end
   end

   // ***********************************************
   // power-good pin drive
   // ***********************************************
   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         good_drive_q <= 1'b0;
      else
         good_drive_q <= bus.aux_good && bus.main_good && !forced;
   end

   // status bits come straight from the comparators, untouched by override
   assign bus.rdata = {bus.aux_good, bus.main_good, 3'b000, gate_q, main_q, aux_q};
   assign bus.main_on = main_on_q;
   assign bus.aux_on = aux_on_q;
   assign bus.good_drive = good_drive_q;

endmodule : slot_power_ctrl

// File: verif/conv_model.sv
`timescale 1ns/1ps
module conv_model
#(
   parameter int DELAY = 8
)
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // request from the register block
   input wire logic start_in,
   input wire logic slot_in,
   input wire logic quantity_in,
   input wire logic [2:0] supply_in,
   input wire logic mute_in,
   // answer
   output logic done_out,
   output logic [7:0] data_out
);
   // data toggles outside the done cycle so a stale sample never passes
   initial
   begin
      done_out = 1'b0;
      data_out = 8'h5A;
   end

   always @(posedge clock_in)
   begin
      data_out <= ~data_out;
      if (start_in === 1'b1 && rst_n_in === 1'b1 && mute_in === 1'b0)
      begin
         repeat (DELAY)
         begin
            @(posedge clock_in);
            data_out <= ~data_out;
         end
         done_out <= 1'b1;
         data_out <= {supply_in, quantity_in, slot_in, 3'h6};
         @(posedge clock_in);
         done_out <= 1'b0;
         data_out <= ~data_out;
      end
   end
endmodule : conv_model

// File: verif/hotplug_adc_slot_control_regs_assertions.sv
`timescale 1ns/1ps
module slot_regs_checker
   import slot_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // register port
   input wire logic [7:0] reg_cmd_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   // converter
   input wire logic conv_start_out,
   input wire logic conv_slot_out,
   input wire logic conv_quantity_out,
   input wire logic [2:0] conv_supply_out,
   // slot pins
   input wire logic slot_a_override_n_in,
   input wire logic slot_a_aux_good_in,
   input wire logic slot_a_main_good_in,
   input wire logic slot_a_main_on_out,
   input wire logic slot_a_aux_on_out,
   input wire logic slot_a_good_n_oe_out,
   input wire logic slot_b_main_on_out,
   input wire logic slot_b_aux_on_out
);
   // ********
   // settle counter: pin lag and reset synchroniser must drain first
   // ********
   logic [2:0] up_q;

   always_ff @(posedge clock_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         up_q <= 3'h0;
      else if (up_q != 3'h7)
         up_q <= up_q + 3'h1;
   end

   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_gate_wr_a;
      reg_wr_in && reg_cmd_in == CMD_SLOT_A && reg_wdata_in[SLOT_GATE_BIT];
   endsequence
   sequence s_gate_wr_b;
      reg_wr_in && reg_cmd_in == CMD_SLOT_B && reg_wdata_in[SLOT_GATE_BIT];
   endsequence

   a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read strobe got no answer");
   a_answer_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
      else $error("read answer without a read");
   a_rdata_hold: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved without a read");
   a_unmapped_zero: assert property (reg_rd_in && reg_cmd_in > CMD_SLOT_B |=> reg_rdata_out == READ_IDLE)
      else $error("unmapped read not zero");
   a_reserved_zero: assert property (reg_rd_in && reg_cmd_in == CMD_CONV_CTRL |=> reg_rdata_out[6:5] == 2'h0)
      else $error("reserved control bits not zero");
   a_start_cause: assert property (conv_start_out |-> $past(reg_wr_in && reg_cmd_in == CMD_CONV_CTRL && reg_wdata_in[2:0] != SUP_NONE))
      else $error("conversion start without a write");
   a_start_fields: assert property (conv_start_out |-> conv_supply_out == $past(reg_wdata_in[2:0]) && conv_slot_out == $past(reg_wdata_in[CONV_SLOT_BIT]) && conv_quantity_out == $past(reg_wdata_in[CONV_QTY_BIT]))
      else $error("conversion fields differ from write");
   a_start_single: assert property (conv_start_out |=> !conv_start_out [*3])
      else $error("conversion restarted while busy");
   a_slot_a_switch: assert property (s_gate_wr_a |-> ##2 slot_a_main_on_out == $past(reg_wdata_in[1], 2) && slot_a_aux_on_out == $past(reg_wdata_in[0], 2))
      else $error("slot a switches differ from write");
   a_slot_b_switch: assert property (s_gate_wr_b |-> ##2 slot_b_main_on_out == $past(reg_wdata_in[1], 2) && slot_b_aux_on_out == $past(reg_wdata_in[0], 2))
      else $error("slot b switches differ from write");
   a_good_needs: assert property (slot_a_good_n_oe_out |-> $past(slot_a_aux_good_in, 3) && $past(slot_a_main_good_in, 3))
      else $error("slot a power good without good status");
   a_good_follows: assert property (up_q == 3'h7 && $past(slot_a_override_n_in, 3) && $past(slot_a_aux_good_in, 3) && $past(slot_a_main_good_in, 3) |-> slot_a_good_n_oe_out)
      else $error("slot a power good not driven");
endmodule : slot_regs_checker

bind hotplug_adc_slot_control_regs slot_regs_checker i_slot_regs_checker (.*);

// File: verif/test_hotplug_adc_slot_control_regs.sv
`timescale 1ns/1ps
module test_hotplug_adc_slot_control_regs
   import slot_ctrl_pkg::*;
;
   // ********
   // stimulus and observed signals
   // ********
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] cmd = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic mute = 1'b0;
   logic [1:0] ovr_n = 2'h3;
   logic [1:0] aux_g = 2'h0;
   logic [1:0] main_g = 2'h0;
   logic [7:0] rdata, data, q;
   logic rvalid, start, sel, qty, done;
   logic [2:0] sup;
   logic [1:0] main_on, aux_on, gn, oe, g;
   logic [7:0] slot_cmd [2] = '{CMD_SLOT_A, CMD_SLOT_B};
   logic [7:0] codes [4] = '{8'h01, 8'h1B, 8'h0D, 8'h15};
   logic [7:0] bad [4] = '{8'h04, 8'h07, 8'h80, 8'hFF};
   int fail_count = 0;
   int compares = 0;
   int nstart = 0;

   always #20 clock_in = ~clock_in;
   always @(posedge clock_in) if (start === 1'b1) nstart++;

   hotplug_adc_slot_control_regs #(.TIMEOUT_CYCLES(20)) i_hotplug_adc_slot_control_regs (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_cmd_in(cmd), .reg_wr_in(wr),
      .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
      .conv_start_out(start), .conv_slot_out(sel), .conv_quantity_out(qty),
      .conv_supply_out(sup), .conv_done_in(done), .conv_data_in(data),
      .slot_a_override_n_in(ovr_n[0]), .slot_a_aux_good_in(aux_g[0]),
      .slot_a_main_good_in(main_g[0]), .slot_a_main_on_out(main_on[0]),
      .slot_a_aux_on_out(aux_on[0]), .slot_a_good_n_out(gn[0]), .slot_a_good_n_oe_out(oe[0]),
      .slot_b_override_n_in(ovr_n[1]), .slot_b_aux_good_in(aux_g[1]),
      .slot_b_main_good_in(main_g[1]), .slot_b_main_on_out(main_on[1]),
      .slot_b_aux_on_out(aux_on[1]), .slot_b_good_n_out(gn[1]), .slot_b_good_n_oe_out(oe[1]));

   conv_model i_conv_model (.clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start),
      .slot_in(sel), .quantity_in(qty), .supply_in(sup), .mute_in(mute), .done_out(done),
      .data_out(data));

   // ********
   // tasks
   // ********
   task automatic test_done;
      $display("compares=%0d fail_count=%0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : test_done

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cycles(input int n);
      repeat (n) @(negedge clock_in);
   endtask : cycles

   task automatic wr_reg(input logic [7:0] c, input logic [7:0] d);
      @(negedge clock_in);
      cmd = c;
      wdata = d;
      wr = 1'b1;
      @(negedge clock_in);
      wr = 1'b0;
   endtask : wr_reg

   // answer lands at the taking edge, so it is sampled just after it
   task automatic rd_reg(input logic [7:0] c, output logic [7:0] r);
      @(negedge clock_in);
      cmd = c;
      rd = 1'b1;
      @(posedge clock_in);
      #1;
      chk({7'h00, rvalid}, 8'h01);
      r = rdata;
      @(negedge clock_in);
      rd = 1'b0;
   endtask : rd_reg

   task automatic rd_chk(input logic [7:0] c, input logic [7:0] exp);
      logic [7:0] r;
      rd_reg(c, r);
      chk(r, exp);
   endtask : rd_chk

   task automatic poll(output logic [7:0] r);
      int n;
      n = 0;
      r = 8'h80;
      while (r[7] !== 1'b0 && n < 40)
      begin
         rd_reg(CMD_CONV_CTRL, r);
         n++;
      end
      if (r[7] !== 1'b0)
      begin
         fail_count++;
         test_done();
      end
   endtask : poll

   task automatic do_reset;
      rst_n_in = 1'b0;
      // status bits follow the good pins, so idle them before reading back zero
      aux_g = 2'h0;
      main_g = 2'h0;
      cycles(8);
      rst_n_in = 1'b1;
      cycles(3);
      for (int c = 0; c < 4; c++) rd_chk(8'(c), 8'h00);
      chk({main_on, aux_on, gn, oe}, 8'h00);
   endtask : do_reset

   // ********
   // sequence
   // ********
   initial
   begin
      do_reset();
      for (int s = 0; s < 2; s++)
      begin
         wr_reg(slot_cmd[s], 8'hFF);
         rd_chk(slot_cmd[s], 8'h07);
         chk({6'h00, main_on[s], aux_on[s]}, 8'h03);
         wr_reg(slot_cmd[s], 8'h05);
         rd_chk(slot_cmd[s], 8'h05);
         chk({6'h00, main_on[s], aux_on[s]}, 8'h01);
      end
      foreach (bad[i])
      begin
         wr_reg(bad[i], 8'hFF);
         rd_chk(bad[i], 8'h00);
      end
      rd_chk(CMD_SLOT_A, 8'h05);
      for (int k = 0; k < 4; k++)
      begin
         g = 2'(k);
         @(negedge clock_in);
         aux_g = {2{g[1]}};
         main_g = {2{g[0]}};
         cycles(4);
         for (int s = 0; s < 2; s++)
         begin
            rd_chk(slot_cmd[s], {g, 6'h05});
            chk({7'h00, oe[s]}, {7'h00, &g});
         end
      end
      @(negedge clock_in);
      ovr_n = 2'h0;
      cycles(4);
      for (int s = 0; s < 2; s++) chk({6'h00, oe[s], main_on[s]}, 8'h02);
      for (int s = 0; s < 2; s++) wr_reg(slot_cmd[s], 8'h01);
      cycles(4);
      for (int s = 0; s < 2; s++)
      begin
         chk({6'h00, oe[s], main_on[s]}, 8'h01);
         rd_chk(slot_cmd[s], 8'hC1);
      end
      @(negedge clock_in);
      ovr_n = 2'h3;
      cycles(4);
      for (int s = 0; s < 2; s++) chk({7'h00, oe[s]}, 8'h01);
      foreach (codes[i])
      begin
         wr_reg(CMD_CONV_CTRL, codes[i]);
         chk({3'h0, sel, qty, sup}, codes[i]);
         rd_chk(CMD_CONV_CTRL, codes[i] | 8'h80);
         poll(q);
         chk(q, codes[i]);
         rd_chk(CMD_RESULT, {codes[i][2:0], codes[i][3], codes[i][4], 3'h6});
      end
      wr_reg(CMD_CONV_CTRL, 8'h78);
      rd_chk(CMD_CONV_CTRL, 8'h18);
      chk(nstart[7:0], 8'h04);
      // a silent converter must still end the conversion
      @(negedge clock_in);
      mute = 1'b1;
      wr_reg(CMD_CONV_CTRL, 8'h09);
      wr_reg(CMD_CONV_CTRL, 8'h1B);
      rd_chk(CMD_CONV_CTRL, 8'h89);
      poll(q);
      rd_chk(CMD_RESULT, 8'hFF);
      mute = 1'b0;
      do_reset();
      test_done();
   end

   initial
   begin
      repeat (20000) @(posedge clock_in);
      fail_count++;
      test_done();
   end
endmodule : test_hotplug_adc_slot_control_regs
